// file: hw/burst_slave.sv
// expansion bus slave card: full cycles, burst short transfers, cache inhibit
// assumes bus strobes are already synchronous to clock_i; write data drains via fifo
//
// Summary of operation
// - locking leaves cycle timing alone; shared-memory cards just watch lock
// - non-cachable slave asserts cache inhibit together with slave select
// - slave latches address, asserts select, and burst ack if burst capable; code also requires burst request asserted at strobe fall
// - burst request or ack negated at cycle start means plain full cycle
// - first data phase: byte strobes and enable, slave answers transfer ack
// - after first transfer master drops strobes and request; slave keeps select
// - slave puts read data out before transfer ack ends a short transfer
// - slave negates burst ack one short transfer early; master does one more
// - never assert burst request or ack without full burst support
// - burst support is optional but recommended, especially for memory
// - slave captures A31-A8 on full strobe falling edge
// - on full strobe negation slave releases select and data lines
`timescale 1ns/100ps
`default_nettype none
module burst_slave #(
  parameter logic [31:0] CARD_BASE = burst_slave_pkg::CARD_BASE_RESET,
  parameter logic [31:0] CARD_MASK = burst_slave_pkg::CARD_MASK_RESET,
  parameter bit NO_CACHE = 1'b1,
  parameter bit BURST_CAPABLE = 1'b1,
  parameter int unsigned BURST_LIMIT = burst_slave_pkg::BURST_LIMIT,
  parameter int unsigned DEPTH = burst_slave_pkg::FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic full_cycle_strobe_n_i,
  input wire logic burst_request_n_i,
  input wire logic data_output_enable_i,
  input wire logic [3:0] byte_strobe_n_i,
  input wire logic read_i,
  input wire logic lock_n_i,
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_n_o,
  output logic slave_select_n_o,
  output logic burst_ack_n_o,
  output logic transfer_ack_n_o,
  output logic cache_inhibit_n_o,
  output logic locked_o,
  input wire logic [31:0] rd_data_i,
  output logic [37:0] wr_data_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [31:0] access_addr_o
);
  localparam int unsigned CW = $clog2(BURST_LIMIT + 1);
  burst_slave_pkg::slave_state_t state_reg, state_next;
  logic [23:0] page_reg, page_next;
  logic [31:0] ad_reg, ad_next, addr_reg, addr_next;
  logic oe_n_reg, oe_n_next, sel_n_reg, sel_n_next, back_n_reg, back_n_next;
  logic tack_n_reg, tack_n_next, cache_inhibit_n_n_reg, cache_inhibit_n_n_next, lock_reg, lock_next;
  logic burst_reg, burst_next, fcs_d_reg;
  logic [CW-1:0] count_reg, count_next;
  logic hit, strobes_on, fifo_in_ready, push;
  assign hit = ((ad_i & CARD_MASK) == (CARD_BASE & CARD_MASK));
  assign strobes_on = data_output_enable_i && (byte_strobe_n_i != 4'hf);
  // write data waits in the fifo; a full fifo holds off the ack
  assign push = (state_reg == burst_slave_pkg::ST_SELECT) && strobes_on && !read_i
    && fifo_in_ready;
  always_comb begin
    state_next = state_reg;
    page_next = page_reg;
    ad_next = ad_reg;
    addr_next = addr_reg;
    oe_n_next = oe_n_reg;
    sel_n_next = sel_n_reg;
    back_n_next = back_n_reg;
    tack_n_next = tack_n_reg;
    cache_inhibit_n_n_next = cache_inhibit_n_n_reg;
    burst_next = burst_reg;
    count_next = count_reg;
    lock_next = !lock_n_i;
    unique case (state_reg)
      burst_slave_pkg::ST_IDLE: begin
        if (fcs_d_reg && !full_cycle_strobe_n_i && hit) begin
          page_next = ad_i[31:burst_slave_pkg::UPPER_LSB];
          sel_n_next = 1'b0;
          cache_inhibit_n_n_next = !NO_CACHE;
          back_n_next = !BURST_CAPABLE || burst_request_n_i;
          burst_next = BURST_CAPABLE && !burst_request_n_i;
          count_next = '0;
          state_next = burst_slave_pkg::ST_SELECT;
        end
      end
      burst_slave_pkg::ST_SELECT: begin
        // write data shares the low lines once strobed, so keep the address taken before
        if (!strobes_on || read_i) begin
          addr_next = {page_reg, ad_i[7:2], 2'b00};
        end
        if (strobes_on && (read_i || fifo_in_ready)) begin
          if (read_i) begin
            ad_next = rd_data_i;
            oe_n_next = 1'b0;
          end
          state_next = burst_slave_pkg::ST_ACK;
        end
      end
      burst_slave_pkg::ST_ACK: begin
        tack_n_next = 1'b0;
        count_next = count_reg + 1'b1;
        // warn one transfer ahead so the master ends after the next one
        if (count_reg + 2 >= CW'(BURST_LIMIT)) begin
          back_n_next = 1'b1;
        end
        if (burst_reg) begin
          state_next = burst_slave_pkg::ST_SHORT_GAP;
        end
      end
      burst_slave_pkg::ST_SHORT_GAP: begin
        if (!burst_request_n_i && byte_strobe_n_i == 4'hf && !read_i) begin
          tack_n_next = 1'b1;
        end
        if (burst_request_n_i && byte_strobe_n_i == 4'hf) begin
          tack_n_next = 1'b1;
          oe_n_next = 1'b1;
        end else if (!burst_request_n_i) begin
          tack_n_next = 1'b1;
          state_next = burst_slave_pkg::ST_SELECT;
        end
      end
      default: state_next = burst_slave_pkg::ST_IDLE;
    endcase
    if (state_reg != burst_slave_pkg::ST_IDLE && full_cycle_strobe_n_i) begin
      sel_n_next = 1'b1;
      oe_n_next = 1'b1;
      tack_n_next = 1'b1;
      back_n_next = 1'b1;
      cache_inhibit_n_n_next = 1'b1;
      state_next = burst_slave_pkg::ST_IDLE;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= burst_slave_pkg::ST_IDLE;
      page_reg <= '0;
      ad_reg <= '0;
      addr_reg <= '0;
      oe_n_reg <= 1'b1;
      sel_n_reg <= 1'b1;
      back_n_reg <= 1'b1;
      tack_n_reg <= 1'b1;
      cache_inhibit_n_n_reg <= 1'b1;
      lock_reg <= 1'b0;
      burst_reg <= 1'b0;
      count_reg <= '0;
      fcs_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      page_reg <= page_next;
      ad_reg <= ad_next;
      addr_reg <= addr_next;
      oe_n_reg <= oe_n_next;
      sel_n_reg <= sel_n_next;
      back_n_reg <= back_n_next;
      tack_n_reg <= tack_n_next;
      cache_inhibit_n_n_reg <= cache_inhibit_n_n_next;
      lock_reg <= lock_next;
      burst_reg <= burst_next;
      count_reg <= count_next;
      fcs_d_reg <= full_cycle_strobe_n_i;
    end
  end
  burst_fifo #(.WIDTH(38), .DEPTH(DEPTH)) u_fifo (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .in_data_i({addr_reg[7:2], ad_i}),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(wr_data_o),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i)
  );
  assign ad_o = ad_reg;
  assign ad_oe_n_o = oe_n_reg;
  assign slave_select_n_o = sel_n_reg;
  assign burst_ack_n_o = back_n_reg;
  assign transfer_ack_n_o = tack_n_reg;
  assign cache_inhibit_n_o = cache_inhibit_n_n_reg;
  assign locked_o = lock_reg;
  assign access_addr_o = addr_reg;

  property p_cache_inhibit_n_with_select;
    @(posedge clock_i) disable iff (srst_i)
      $fell(slave_select_n_o) |-> (cache_inhibit_n_o == !NO_CACHE);
  endproperty
  a_cache_inhibit_n_with_select: assert property (p_cache_inhibit_n_with_select) else $error("cache_inhibit_n not with select");
  property p_release_on_fcs;
    @(posedge clock_i) disable iff (srst_i)
      (full_cycle_strobe_n_i && state_reg != burst_slave_pkg::ST_IDLE) |=> slave_select_n_o
        && ad_oe_n_o;
  endproperty
  a_release_on_fcs: assert property (p_release_on_fcs) else $error("no release on strobe");
  property p_no_back_without_req;
    @(posedge clock_i) disable iff (srst_i)
      $fell(slave_select_n_o) && !burst_reg |-> burst_ack_n_o;
  endproperty
  a_no_back_without_req: assert property (p_no_back_without_req) else $error("ack w/o req");
  sequence s_ack_then_hold;
    !transfer_ack_n_o && burst_reg && !full_cycle_strobe_n_i;
  endsequence
  property p_hold_select;
    @(posedge clock_i) disable iff (srst_i)
      s_ack_then_hold |-> !slave_select_n_o;
  endproperty
  a_hold_select: assert property (p_hold_select) else $error("select dropped in burst");
  property p_data_before_ack;
    @(posedge clock_i) disable iff (srst_i)
      $fell(transfer_ack_n_o) && read_i |-> !ad_oe_n_o;
  endproperty
  a_data_before_ack: assert property (p_data_before_ack) else $error("ack before data");
  property p_page_stable;
    @(posedge clock_i) disable iff (srst_i)
      !slave_select_n_o && $past(!slave_select_n_o) |-> $stable(page_reg);
  endproperty
  a_page_stable: assert property (p_page_stable) else $error("page changed");
  property p_lock_follow;
    @(posedge clock_i) disable iff (srst_i)
      !lock_n_i |=> locked_o;
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock not seen");
  property p_early_back;
    @(posedge clock_i) disable iff (srst_i)
      (state_reg == burst_slave_pkg::ST_ACK && count_reg + 2 >= CW'(BURST_LIMIT)
        && !full_cycle_strobe_n_i) |=> burst_ack_n_o;
  endproperty
  a_early_back: assert property (p_early_back) else $error("ack not dropped early");
endmodule // burst_slave
`default_nettype wire

// file: hw/burst_slave_pkg.sv
// package for the expansion bus burst-capable slave card logic
// assumes a single 50 MHz logic clock; bus strobes arrive pre-synchronised
package burst_slave_pkg;
  localparam int unsigned CLOCK_HZ = 50_000_000;
  localparam int unsigned ADDR_WIDTH = 32;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned UPPER_LSB = 8;
  localparam int unsigned LOW_ADDR_MSB = 7;
  localparam int unsigned LOW_ADDR_LSB = 2;
  localparam int unsigned BURST_LIMIT = 16;
  localparam logic [31:0] CARD_BASE_RESET = 32'h4000_0000;
  localparam logic [31:0] CARD_MASK_RESET = 32'hff00_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SELECT = 2'b01,
    ST_ACK = 2'b11,
    ST_SHORT_GAP = 2'b10
  } slave_state_t;
endpackage

// file: hw/burst_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module burst_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] count_reg, count_next;
  logic push, pop;
  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    count_next = count_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      count_reg <= count_next;
    end
  end
  // storage needs no reset; only written on a push
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
endmodule // burst_fifo
`default_nettype wire

// file: tb/bus_master_model.sv
// bus master model: address phase, bursts, short transfers
// assumes the slave card registers its answers on clock_i
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
  input wire logic clock_i,
  input wire logic tack_n_i,
  input wire logic back_n_i,
  input wire logic [31:0] rd_i,
  output logic fcs_n_o,
  output logic req_n_o,
  output logic doe_o,
  output logic [3:0] ds_n_o,
  output logic read_o,
  output logic [31:0] ad_o
);
  logic more;
  logic [31:0] rdat;
  initial {fcs_n_o, req_n_o, doe_o, ds_n_o, read_o, ad_o} = {7'h6f, 1'b1, 32'h0};
  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask
  task automatic open(input logic [31:0] a, input logic burst);
    tick();
    ad_o = a;
    fcs_n_o = 1'b0;
    req_n_o = !burst;
    tick();
    ad_o = ~a;
  endtask
  // write data trails the request by a cycle; reads strobe together with it
  task automatic xfer(input logic rd, input logic [5:0] lo, input logic [31:0] wd,
    input logic first, input logic stop, output logic ok, output logic fin);
    int n;
    read_o = rd;
    ad_o[7:2] = lo;
    doe_o = 1'b1;
    if (!first) req_n_o = 1'b0;
    if (!rd) begin
      tick();
      ad_o = wd;
    end
    ds_n_o = 4'h0;
    tick();
    more = !back_n_i;
    for (n = 0; n < 40 && tack_n_i; n++) tick();
    ok = !tack_n_i;
    rdat = rd_i;
    fin = stop || !more;
    {ds_n_o, req_n_o} = 5'h1f;
    // low address lines stay driven; released data lines show the inverse
    ad_o = {~ad_o[31:8], ad_o[7:2], ~ad_o[1:0]};
    if (fin) {fcs_n_o, doe_o} = 2'b10;
    tick();
  endtask
endmodule // bus_master_model
`default_nettype wire

// file: tb/expansion_burst_lock_cache_cycles_test.sv
// bench for the burst-capable expansion bus slave card
// assumes bus_master_model drives the bus; bench drives lock, card data and drain
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t mismatch", $time); end end
module expansion_burst_lock_cache_cycles_test;
  localparam int unsigned LIM = 6;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1, lock_n = 1'b1, wr_ready = 1'b0;
  logic [31:0] rdd = 32'h0;
  logic fcs_n, req_n, data_output_enable, rd, tack_n, back_n, sel_n, cache_inhibit_n_n, oe_n, locked, wvalid, ok, fin;
  logic [3:0] ds_n;
  logic [31:0] ad_m, ad_s, aaddr;
  logic [37:0] wdata;
  int errors = 0;
  int compares = 0;
  always #10 clock_i = ~clock_i;
  bus_master_model m (.clock_i(clock_i), .tack_n_i(tack_n), .back_n_i(back_n), .rd_i(ad_s),
    .fcs_n_o(fcs_n), .req_n_o(req_n), .doe_o(data_output_enable), .ds_n_o(ds_n), .read_o(rd), .ad_o(ad_m));
  burst_slave #(.BURST_LIMIT(LIM)) dut (.clock_i(clock_i), .srst_i(srst_i),
    .full_cycle_strobe_n_i(fcs_n), .burst_request_n_i(req_n), .data_output_enable_i(data_output_enable),
    .byte_strobe_n_i(ds_n), .read_i(rd), .lock_n_i(lock_n), .ad_i(ad_m), .ad_o(ad_s),
    .ad_oe_n_o(oe_n), .slave_select_n_o(sel_n), .burst_ack_n_o(back_n),
    .transfer_ack_n_o(tack_n), .cache_inhibit_n_o(cache_inhibit_n_n), .locked_o(locked),
    .rd_data_i(rdd), .wr_data_o(wdata), .wr_valid_o(wvalid), .wr_ready_i(wr_ready),
    .access_addr_o(aaddr));
  task automatic start(input logic [31:0] a, input logic burst);
    m.open(a, burst);
    m.tick();
    `CHK({sel_n, cache_inhibit_n_n, back_n}, {2'b00, !burst})
  endtask
  task automatic rdx(input logic [5:0] lo, input logic first, input logic stop);
    rdd = {8'hbe, 18'h0, lo};
    m.xfer(1'b1, lo, 32'h0, first, stop, ok, fin);
    `CHK({ok, m.rdat, aaddr[7:0]}, {1'b1, rdd, lo, 2'b00})
  endtask
  task automatic t_reset();
    repeat (10) m.tick();
    `CHK({sel_n, back_n, tack_n, cache_inhibit_n_n, oe_n, locked}, 6'h3e)
    srst_i = 1'b0;
    m.open(32'h8000_0000, 1'b1);
    repeat (3) m.tick();
    `CHK({sel_n, back_n, cache_inhibit_n_n}, 3'h7)
    {m.fcs_n_o, m.req_n_o} = 2'b11;
    $display("test reset and miss done");
  endtask
  task automatic t_single();
    start(32'h4012_3414, 1'b0);
    rdx(6'h05, 1'b1, 1'b0);
    `CHK({fin, aaddr[31:8]}, {1'b1, 24'h401234})
    repeat (2) m.tick();
    `CHK({sel_n, oe_n}, 2'b11)
    $display("test single read done");
  endtask
  task automatic t_burst();
    int i;
    lock_n = 1'b0;
    start(32'h4055_6600, 1'b1);
    `CHK(locked, 1'b1)
    for (i = 0; i < 3; i++) begin
      rdx(6'(i * 21), i == 0, i == 2);
      `CHK({fin, aaddr[31:8]}, {i == 2, 24'h405566})
      if (i < 2) `CHK(sel_n, 1'b0)
    end
    lock_n = 1'b1;
    repeat (2) m.tick();
    `CHK(locked, 1'b0)
    $display("test burst read done");
  endtask
  task automatic t_limit();
    int n;
    start(32'h4000_1000, 1'b1);
    fin = 1'b0;
    for (n = 0; n < 20 && !fin; n++) rdx(6'(n), n == 0, 1'b0);
    `CHK(n == LIM, 1'b1)
    $display("test burst limit done");
  endtask
  task automatic t_fifo();
    int i, k = 0;
    for (i = 0; i < 8; i++) begin
      start(32'h4077_0000, 1'b0);
      m.xfer(1'b0, 6'h00, 32'hd000_0000 + i, 1'b1, 1'b1, ok, fin);
      `CHK(ok, 1'b1)
    end
    start(32'h4077_0000, 1'b0);
    // the ninth word must wait for room, so its acknowledge is held back
    fork
      m.xfer(1'b0, 6'h00, 32'hd000_0008, 1'b1, 1'b1, ok, fin);
      begin
        repeat (10) m.tick();
        `CHK({tack_n, wvalid}, 2'b11)
        wr_ready = 1'b1;
        for (i = 0; i < 40 && k < 9; i++) begin
          if (wvalid === 1'b1) begin
            `CHK(wdata[31:0], 32'hd000_0000 + k)
            `CHK(wdata[37:32], 6'h00)
            k++;
          end
          m.tick();
        end
      end
    join
    `CHK({ok, wvalid, k == 9}, 3'b101)
    $display("test write fifo done");
  endtask
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    t_reset();
    t_single();
    t_burst();
    t_limit();
    t_fifo();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    conclude();
  end
endmodule // expansion_burst_lock_cache_cycles_test
`default_nettype wire
